// ### common/lcdcps_pkg.sv
// package: opcodes, field positions, reset values and geometry of the lcd command decoder
package lcdcps_pkg;
  // opcode patterns (full byte or prefix)
  localparam logic [6:0] LCDCPS_OP_DISP_ONOFF = 7'h57; // 1010111x
  localparam logic [6:0] LCDCPS_OP_COL_ORDER = 7'h50; // 1010000x
  localparam logic [6:0] LCDCPS_OP_BIAS = 7'h51; // 1010001x
  localparam logic [6:0] LCDCPS_OP_ENTIRE = 7'h52; // 1010010x
  localparam logic [6:0] LCDCPS_OP_REVERSE = 7'h53; // 1010011x
  localparam logic [6:0] LCDCPS_OP_STATIC_ONOFF = 7'h56; // 1010110x
  localparam logic [1:0] LCDCPS_OP_START_LINE = 2'h1; // 01xxxxxx
  localparam logic [3:0] LCDCPS_OP_PAGE = 4'hb; // 1011xxxx
  localparam logic [3:0] LCDCPS_OP_COL_HI = 4'h1; // 0001xxxx
  localparam logic [3:0] LCDCPS_OP_COL_LO = 4'h0; // 0000xxxx
  localparam logic [3:0] LCDCPS_OP_TEST = 4'hf; // 1111xxxx
  localparam logic [3:0] LCDCPS_OP_COM_DIR = 4'hc; // 1100xxxx
  localparam logic [7:0] LCDCPS_OP_RMW = 8'he0;
  localparam logic [7:0] LCDCPS_OP_END = 8'hee;
  localparam logic [7:0] LCDCPS_OP_RESET = 8'he2;
  localparam logic [7:0] LCDCPS_OP_NOP = 8'he3;
  // field positions
  localparam int LCDCPS_LSB_BIT = 0;
  localparam int LCDCPS_START_W = 6;
  localparam int LCDCPS_PAGE_W = 4;
  localparam int LCDCPS_NIB_W = 4;
  localparam int LCDCPS_COM_DIR_BIT = 3;
  localparam int LCDCPS_IND_W = 2;
  // status byte bit positions (low nibble reads zero)
  localparam int LCDCPS_ST_BUSY = 7;
  localparam int LCDCPS_ST_COLORD = 6;
  localparam int LCDCPS_ST_ONOFF = 5;
  localparam int LCDCPS_ST_RESET = 4;
  // ram geometry
  localparam int LCDCPS_PAGES = 9;
  localparam int LCDCPS_COLS = 132;
  localparam int LCDCPS_COL_W = 8;
  // reset values
  localparam logic [7:0] LCDCPS_COL_RST = 8'h00;
  localparam logic [3:0] LCDCPS_PAGE_RST = 4'h0;
  localparam logic [5:0] LCDCPS_START_RST = 6'h00;
  localparam logic [1:0] LCDCPS_IND_RST = 2'h0;
  // power states
  typedef enum logic [1:0] {LCDCPS_PWR_RUN, LCDCPS_PWR_SLEEP, LCDCPS_PWR_STANDBY} lcdcps_pwr_t;
endpackage

// ### design/lcdcps_ram.sv
// display ram: page by column byte store with a registered read port
`timescale 1ns/10ps
module lcdcps_ram
  import lcdcps_pkg::*;
#(
  parameter int PAGES = LCDCPS_PAGES,
  parameter int COLS = LCDCPS_COLS
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [3:0] page,
  input wire logic [7:0] col,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  logic [7:0] mem [PAGES*COLS];
  logic [31:0] idx;

  // flat index; out-of-range addresses are dropped on write
  assign idx = 32'(page) * 32'(COLS) + 32'(col);

  // write port, contents survive every reset
  always_ff @(posedge clk) begin
    if (wr_en && (32'(page) < 32'(PAGES)) && (32'(col) < 32'(COLS))) begin
      mem[idx] <= wr_data;
    end
  end

  // read port, out of range reads zero
  always_ff @(posedge clk) begin
    if ((32'(page) < 32'(PAGES)) && (32'(col) < 32'(COLS))) begin
      rd_data <= mem[idx];
    end else begin
      rd_data <= 8'h00;
    end
  end
endmodule // lcdcps_ram

// ### design/lcdcps_decoder.sv
// command decoder and power-save state logic of the lcd controller
//
// Notes on behaviour
// [RULE1] display off plus entire display on forms a power save request
// [RULE2] power save goes to sleep if indicator off, standby if on
// [RULE3] release plus indicator on command leaves sleep
// [RULE4] sleep stops oscillator and power, driver outputs held at ground
// [RULE5] sleep and standby keep ram and all mode settings
// [RULE6] ram stays readable and writable in sleep and standby
// [RULE7] standby stops power and multiplex drive, indicator keeps running
// [RULE8] software reset in standby moves the device into sleep
// [RULE9] upper nibble 1111 enters test mode; hard or soft reset leaves it
// [RULE10] host never issues the test command in normal use
// [RULE11] host should refresh state including the test mode reset byte
// [RULE12] data select high: writes store to ram, reads return ram
// [RULE13] display on/off command sets panel on with bit one
// [RULE14] top bits 01 load the six-bit display start line
// [RULE15] upper nibble 1011 loads the page address
// [RULE16] nibbles 0001 and 0000 load column high and low halves
// [RULE17] status read returns flags high, low four bits zero
// [RULE18] column order command picks column to driver correspondence
// [RULE19] reverse command selects normal or inverted pixel polarity
// [RULE20] entire display command forces all pixels on when set
// [RULE21] bias command selects one of two bias ratios
// [RULE22] read-modify-write advances column on writes only; end cancels
// [RULE23] after indicator on only the indicator register set is taken
// [RULE24] software reset clears addressing and modes, not ram; col_reverse, pixel_reverse and bias_sel keep their values
// [RULE25] undefined command bytes change nothing
`timescale 1ns/10ps
module lcdcps_decoder
  import lcdcps_pkg::*;
#(
  parameter int PAGES = LCDCPS_PAGES,
  parameter int COLS = LCDCPS_COLS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hard_init_pin_n,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic command_data_select,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic display_on,
  output logic [5:0] start_line,
  output logic [3:0] page_addr,
  output logic [7:0] col_addr,
  output logic col_reverse,
  output logic pixel_reverse,
  output logic entire_on,
  output logic bias_sel,
  output logic com_reverse,
  output logic rmw_mode,
  output logic test_mode,
  output logic static_ind_on,
  output logic [1:0] static_ind_mode,
  output logic osc_enable,
  output logic power_enable,
  output logic lcd_drive_enable,
  output logic drivers_grounded,
  output logic static_drive_enable,
  output logic sleep_mode,
  output logic standby_mode
);
  logic rst_any;
  logic cmd_wr;
  logic data_wr;
  logic data_rd;
  logic st_rd;
  logic ind_lock_q;
  logic ram_rd_pend_q;
  logic st_rd_pend_q;
  logic rd_vld_q;
  logic [7:0] status_q;
  logic [7:0] ram_q;
  logic soft_reset;
  logic release_cmd;
  logic rel_pend_q;
  lcdcps_pwr_t pwr_q;
  lcdcps_pwr_t pwr_d;
  logic disp_d;
  logic entire_d;

  // prefix match helper for the seven-bit opcodes; other prefixes are compared directly
  function automatic logic op7(input logic [7:0] b, input logic [6:0] op);
    return b[7:1] == op;
  endfunction

  // host strobes split by select line; hard pin joins system reset
  assign rst_any = sys_rst || !hard_init_pin_n; // [RULE9]
  assign cmd_wr = wr_strobe && !command_data_select;
  assign data_wr = wr_strobe && command_data_select; // [RULE12]
  assign data_rd = rd_strobe && command_data_select; // [RULE12]
  assign st_rd = rd_strobe && !command_data_select;
  // the locked byte after indicator on is never decoded as an opcode
  assign soft_reset = cmd_wr && !ind_lock_q && (wr_data == LCDCPS_OP_RESET);

  // display ram, never cleared by any reset
  lcdcps_ram #(
    .PAGES(PAGES),
    .COLS(COLS)
  ) u_ram (
    .clk(clk),
    .wr_en(data_wr), // [RULE6]
    .page(page_addr),
    .col(col_addr),
    .wr_data(wr_data),
    .rd_data(ram_q)
  );

  // display on/off and entire display flags
  always_comb begin
    disp_d = display_on;
    entire_d = entire_on;
    if (cmd_wr && !ind_lock_q && op7(wr_data, LCDCPS_OP_DISP_ONOFF)) begin
      disp_d = wr_data[LCDCPS_LSB_BIT]; // [RULE13]
    end
    if (cmd_wr && !ind_lock_q && op7(wr_data, LCDCPS_OP_ENTIRE)) begin
      entire_d = wr_data[LCDCPS_LSB_BIT]; // [RULE20]
    end
  end

  always_ff @(posedge clk) begin
    if (rst_any || soft_reset) begin
      display_on <= 1'b0;
      entire_on <= 1'b0;
    end else begin
      display_on <= disp_d;
      entire_on <= entire_d;
    end
  end

  // single-bit mode settings; kept through sleep and standby
  always_ff @(posedge clk) begin
    if (rst_any) begin
      col_reverse <= 1'b0;
      pixel_reverse <= 1'b0;
      bias_sel <= 1'b0;
    end else if (cmd_wr && !ind_lock_q) begin // [RULE5] [RULE25]
      if (op7(wr_data, LCDCPS_OP_COL_ORDER)) begin
        col_reverse <= wr_data[LCDCPS_LSB_BIT]; // [RULE18]
      end
      if (op7(wr_data, LCDCPS_OP_REVERSE)) begin
        pixel_reverse <= wr_data[LCDCPS_LSB_BIT]; // [RULE19]
      end
      if (op7(wr_data, LCDCPS_OP_BIAS)) begin
        bias_sel <= wr_data[LCDCPS_LSB_BIT]; // [RULE21]
      end
    end
  end

  // start line, page, common direction; soft reset clears them
  always_ff @(posedge clk) begin
    if (rst_any || soft_reset) begin // [RULE24]
      start_line <= LCDCPS_START_RST;
      page_addr <= LCDCPS_PAGE_RST;
      com_reverse <= 1'b0;
    end else if (cmd_wr && !ind_lock_q) begin
      if (wr_data[7:6] == LCDCPS_OP_START_LINE) begin
        start_line <= wr_data[LCDCPS_START_W-1:0]; // [RULE14]
      end
      if (wr_data[7:4] == LCDCPS_OP_PAGE) begin
        page_addr <= wr_data[LCDCPS_PAGE_W-1:0]; // [RULE15]
      end
      if (wr_data[7:4] == LCDCPS_OP_COM_DIR) begin
        com_reverse <= wr_data[LCDCPS_COM_DIR_BIT];
      end
    end
  end

  // column counter: nibble loads, auto advance on data access
  always_ff @(posedge clk) begin
    if (rst_any || soft_reset) begin // [RULE24]
      col_addr <= LCDCPS_COL_RST;
    end else if (cmd_wr && !ind_lock_q && wr_data[7:4] == LCDCPS_OP_COL_HI) begin
      col_addr <= {wr_data[LCDCPS_NIB_W-1:0], col_addr[3:0]}; // [RULE16]
    end else if (cmd_wr && !ind_lock_q && wr_data[7:4] == LCDCPS_OP_COL_LO) begin
      col_addr <= {col_addr[7:4], wr_data[LCDCPS_NIB_W-1:0]}; // [RULE16]
    end else if (data_wr || (data_rd && !rmw_mode)) begin // [RULE22]
      if (32'(col_addr) < 32'(COLS - 1)) begin
        col_addr <= col_addr + 8'h01;
      end
    end
  end

  // read-modify-write and test mode flags
  always_ff @(posedge clk) begin
    if (rst_any || soft_reset) begin // [RULE9]
      rmw_mode <= 1'b0;
      test_mode <= 1'b0;
    end else if (cmd_wr && !ind_lock_q) begin
      if (wr_data == LCDCPS_OP_RMW) begin
        rmw_mode <= 1'b1; // [RULE22]
      end else if (wr_data == LCDCPS_OP_END) begin
        rmw_mode <= 1'b0; // [RULE22]
      end
      if (wr_data[7:4] == LCDCPS_OP_TEST) begin
        test_mode <= (wr_data != {LCDCPS_OP_TEST, 4'h0}); // [RULE9]
      end
    end
  end

  // static indicator on/off, register set lock and blink mode
  always_ff @(posedge clk) begin
    if (rst_any || soft_reset) begin
      ind_lock_q <= 1'b0;
      static_ind_on <= 1'b0;
      static_ind_mode <= LCDCPS_IND_RST;
    end else if (cmd_wr && ind_lock_q) begin
      static_ind_mode <= wr_data[LCDCPS_IND_W-1:0]; // [RULE23]
      ind_lock_q <= 1'b0; // [RULE23]
    end else if (cmd_wr && op7(wr_data, LCDCPS_OP_STATIC_ONOFF)) begin
      static_ind_on <= wr_data[LCDCPS_LSB_BIT];
      ind_lock_q <= wr_data[LCDCPS_LSB_BIT];
    end
  end

  // a power save release seen in sleep waits for the indicator on command
  assign release_cmd = cmd_wr && !ind_lock_q &&
    ((op7(wr_data, LCDCPS_OP_DISP_ONOFF) && wr_data[0]) ||
     (op7(wr_data, LCDCPS_OP_ENTIRE) && !wr_data[0]));

  always_ff @(posedge clk) begin
    if (rst_any || pwr_q != LCDCPS_PWR_SLEEP) begin
      rel_pend_q <= 1'b0;
    end else if (release_cmd) begin
      rel_pend_q <= 1'b1; // [RULE3]
    end
  end

  // power state selection
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      LCDCPS_PWR_RUN: begin
        if (!disp_d && entire_d && !soft_reset) begin // [RULE1]
          pwr_d = static_ind_on ? LCDCPS_PWR_STANDBY : LCDCPS_PWR_SLEEP; // [RULE2]
        end
      end
      LCDCPS_PWR_SLEEP: begin
        if (rel_pend_q && cmd_wr && !ind_lock_q &&
            op7(wr_data, LCDCPS_OP_STATIC_ONOFF) && wr_data[0]) begin
          pwr_d = LCDCPS_PWR_RUN; // [RULE3]
        end
      end
      LCDCPS_PWR_STANDBY: begin
        if (soft_reset) begin
          pwr_d = LCDCPS_PWR_SLEEP; // [RULE8]
        end else if (disp_d || !entire_d) begin
          pwr_d = LCDCPS_PWR_RUN;
        end
      end
      default: pwr_d = LCDCPS_PWR_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst_any) begin
      pwr_q <= LCDCPS_PWR_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // power and drive controls decoded from the state
  assign sleep_mode = (pwr_q == LCDCPS_PWR_SLEEP);
  assign standby_mode = (pwr_q == LCDCPS_PWR_STANDBY);
  assign osc_enable = !sleep_mode; // [RULE4]
  assign power_enable = (pwr_q == LCDCPS_PWR_RUN); // [RULE7]
  assign lcd_drive_enable = power_enable && display_on; // [RULE4]
  assign drivers_grounded = !power_enable; // [RULE7]
  assign static_drive_enable = standby_mode || (power_enable && static_ind_on); // [RULE7]

  // read path: status or ram byte, valid two cycles after the strobe
  always_ff @(posedge clk) begin
    if (rst_any) begin
      ram_rd_pend_q <= 1'b0;
      rd_vld_q <= 1'b0;
      st_rd_pend_q <= 1'b0;
      status_q <= 8'h00;
    end else begin
      ram_rd_pend_q <= data_rd; // [RULE6]
      rd_vld_q <= ram_rd_pend_q || st_rd_pend_q; // lands with rd_data
      st_rd_pend_q <= st_rd;
      if (st_rd) begin
        status_q <= 8'h00; // [RULE17]
        status_q[LCDCPS_ST_COLORD] <= col_reverse;
        status_q[LCDCPS_ST_ONOFF] <= !display_on;
        status_q[LCDCPS_ST_BUSY] <= 1'b0;
        status_q[LCDCPS_ST_RESET] <= 1'b0;
      end
    end
  end

  // valid flag trails the pending bits so it never flags a stale byte
  assign rd_valid = rd_vld_q;

  always_ff @(posedge clk) begin
    if (rst_any) begin
      rd_data <= 8'h00;
    end else if (ram_rd_pend_q) begin
      rd_data <= ram_q; // [RULE12]
    end else if (st_rd_pend_q) begin
      rd_data <= status_q; // [RULE17]
    end
  end
endmodule // lcdcps_decoder

// ### bench/lcdcps_props.sv
// checker: concurrent properties on the decoder ports
`timescale 1ns/10ps
module lcdcps_props
  import lcdcps_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hard_init_pin_n,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic command_data_select,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic display_on,
  input wire logic [7:0] col_addr,
  input wire logic entire_on,
  input wire logic rmw_mode,
  input wire logic test_mode,
  input wire logic static_ind_on,
  input wire logic [1:0] static_ind_mode,
  input wire logic osc_enable,
  input wire logic power_enable,
  input wire logic drivers_grounded,
  input wire logic static_drive_enable,
  input wire logic sleep_mode,
  input wire logic standby_mode
);
  logic lock_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !hard_init_pin_n);
  // mirrors the indicator lock so that gated bytes are not read as commands
  always_ff @(posedge clk) begin
    if (sys_rst || !hard_init_pin_n) lock_q <= 1'b0;
    else if (wr_strobe && !command_data_select) lock_q <= !lock_q && wr_data == 8'had;
  end
  sequence s_cmd;
    wr_strobe && !command_data_select && !lock_q;
  endsequence
  sequence s_dat_rd;
    rd_strobe && command_data_select;
  endsequence
  chk_save_sleep: assert property ($rose(sleep_mode) && !$past(standby_mode) |->
    !static_ind_on && !display_on && entire_on) else $error("sleep entered wrongly");
  chk_save_standby: assert property ($rose(standby_mode) |->
    static_ind_on && !display_on && entire_on) else $error("standby entered wrongly");
  chk_sleep_outputs: assert property (sleep_mode |->
    !osc_enable && !power_enable && drivers_grounded) else $error("sleep outputs wrong");
  chk_standby_outputs: assert property (standby_mode |-> osc_enable && !power_enable
    && drivers_grounded && static_drive_enable) else $error("standby outputs wrong");
  chk_reset_to_sleep: assert property (standby_mode ##0 s_cmd ##0 wr_data == 8'he2
    |=> sleep_mode && !standby_mode) else $error("reset in standby missed sleep");
  chk_test_entry: assert property (s_cmd ##0 wr_data[7:4] == LCDCPS_OP_TEST
    |=> test_mode == (|$past(wr_data[3:0]))) else $error("test mode wrong");
  chk_status_low: assert property (rd_strobe && !command_data_select
    |-> ##2 rd_valid && rd_data[3:0] == 4'h0 && !rd_data[7]) else $error("status bad");
  chk_display_cmd: assert property (s_cmd ##0 wr_data[7:1] == LCDCPS_OP_DISP_ONOFF
    |=> display_on == $past(wr_data[0])) else $error("display flag wrong");
  chk_rmw_hold: assert property (rmw_mode ##0 s_dat_rd |=> $stable(col_addr))
    else $error("column moved on read");
  chk_lock_only: assert property (lock_q && wr_strobe && !command_data_select |=>
    static_ind_mode == $past(wr_data[1:0]) && $stable(display_on) && $stable(test_mode))
    else $error("locked byte misread");
endmodule // lcdcps_props
bind lcdcps_decoder lcdcps_props i_props (.clk(clk), .sys_rst(sys_rst),
  .hard_init_pin_n(hard_init_pin_n), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
  .command_data_select(command_data_select), .wr_data(wr_data), .rd_data(rd_data),
  .rd_valid(rd_valid), .display_on(display_on), .col_addr(col_addr), .entire_on(entire_on),
  .rmw_mode(rmw_mode), .test_mode(test_mode), .static_ind_on(static_ind_on),
  .static_ind_mode(static_ind_mode), .osc_enable(osc_enable), .power_enable(power_enable),
  .drivers_grounded(drivers_grounded), .static_drive_enable(static_drive_enable),
  .sleep_mode(sleep_mode), .standby_mode(standby_mode));

// ### bench/lcdcps_host.sv
// host model: byte writes and reads on the decoder bus
`timescale 1ns/10ps
module lcdcps_host (
  input wire logic clk,
  output logic wr_strobe,
  output logic rd_strobe,
  output logic command_data_select,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  // idle bus at time zero
  initial begin
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    command_data_select = 1'b0;
    wr_data = 8'h00;
  end
  // one-cycle write; test bytes go out only when the bench asks
  task automatic put(input logic sel, input logic [7:0] b);
    @(negedge clk);
    wr_strobe = 1'b1;
    command_data_select = sel;
    wr_data = b;
    @(negedge clk);
    wr_strobe = 1'b0;
    command_data_select = ~sel;
    wr_data = ~b;
  endtask
  // one-cycle read, answer taken while rd_valid stands
  task automatic get(input logic sel, output logic [7:0] b);
    b = 8'h00;
    @(negedge clk);
    rd_strobe = 1'b1;
    command_data_select = sel;
    @(negedge clk);
    rd_strobe = 1'b0;
    command_data_select = ~sel;
    for (int n = 0; n < 4; n++) begin
      if (rd_valid === 1'b1) begin
        b = rd_data;
        break;
      end
      @(negedge clk);
    end
  endtask
  // periodic refresh clears any stray test mode
  task automatic refresh;
    put(1'b0, 8'hf0);
  endtask
endmodule // lcdcps_host

// ### bench/tb_top.sv
// testbench: random and corner command traffic into the decoder
`timescale 1ns/10ps
module tb_top;
  import lcdcps_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hard_init_pin_n = 1'b1;
  logic wr_strobe, rd_strobe, command_data_select, rd_valid, display_on, col_reverse;
  logic pixel_reverse, entire_on, bias_sel, com_reverse, rmw_mode, test_mode, static_ind_on;
  logic osc_enable, power_enable, lcd_drive_enable, drivers_grounded, static_drive_enable;
  logic sleep_mode, standby_mode;
  logic [7:0] wr_data, rd_data, col_addr, b, c;
  logic [7:0] mem [3];
  logic [5:0] start_line, sl;
  logic [3:0] page_addr, pg, fe;
  logic [1:0] static_ind_mode;
  logic [6:0] ops [4] = '{LCDCPS_OP_COL_ORDER, LCDCPS_OP_BIAS, LCDCPS_OP_REVERSE,
    LCDCPS_OP_DISP_ONOFF};
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  wire logic [3:0] fl = {display_on, pixel_reverse, bias_sel, col_reverse};
  always #2.5 clk = ~clk;
  lcdcps_decoder i_lcdcps_decoder (.clk(clk), .sys_rst(sys_rst),
    .hard_init_pin_n(hard_init_pin_n), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .command_data_select(command_data_select), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .display_on(display_on), .start_line(start_line),
    .page_addr(page_addr), .col_addr(col_addr), .col_reverse(col_reverse),
    .pixel_reverse(pixel_reverse), .entire_on(entire_on), .bias_sel(bias_sel),
    .com_reverse(com_reverse), .rmw_mode(rmw_mode), .test_mode(test_mode),
    .static_ind_on(static_ind_on), .static_ind_mode(static_ind_mode),
    .osc_enable(osc_enable), .power_enable(power_enable),
    .lcd_drive_enable(lcd_drive_enable), .drivers_grounded(drivers_grounded),
    .static_drive_enable(static_drive_enable), .sleep_mode(sleep_mode),
    .standby_mode(standby_mode));
  lcdcps_host u_host (.clk(clk), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .command_data_select(command_data_select), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid));
  // expected status byte from the tracked flags
  function automatic logic [7:0] st_exp(input logic cr, input logic d);
    return {1'b0, cr, !d, 1'b0, 4'h0};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chb(input string n, input logic e, input logic g);
    chk(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic cmd(input logic [7:0] v);
    u_host.put(1'b0, v);
  endtask
  task automatic setcol(input logic [7:0] v);
    cmd({4'h1, v[7:4]});
    cmd({4'h0, v[3:0]});
  endtask
  task automatic wake;
    cmd(8'ha4);
    cmd(8'had);
    cmd(8'h03);
  endtask
  task automatic stop_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // cuts a hung run short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test;
    end
  end
  // main sequence
  initial begin
    void'($urandom(53507));
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    for (int r = 0; r < 12; r++) begin
      fe[r % 4] = 1'($urandom_range(1));
      cmd({ops[r % 4], fe[r % 4]});
      chb("mode", fe[r % 4], fl[r % 4]);
    end
    cmd(8'ha4);
    chb("entire", 1'b0, entire_on);
    chb("drive", fe[3], lcd_drive_enable);
    $display("end of test modes");
    sl = 6'($urandom);
    pg = 4'($urandom_range(8));
    c = 8'($urandom_range(128));
    cmd({2'h1, sl});
    cmd({4'hb, pg});
    setcol(c);
    chk("start", {2'h0, sl}, {2'h0, start_line});
    chk("page", {4'h0, pg}, {4'h0, page_addr});
    chk("col", c, col_addr);
    for (int i = 0; i < 3; i++) begin
      mem[i] = 8'($urandom);
      u_host.put(1'b1, mem[i]);
    end
    setcol(c);
    for (int i = 0; i < 3; i++) begin
      u_host.get(1'b1, b);
      chk("ram", mem[i], b);
    end
    cmd(8'he0);
    setcol(c);
    u_host.get(1'b1, b);
    chk("rmw col", c, col_addr);
    u_host.put(1'b1, ~mem[0]);
    chk("rmw wr col", c + 8'h01, col_addr);
    cmd(8'hee);
    chb("rmw end", 1'b0, rmw_mode);
    u_host.get(1'b0, b);
    chk("status", st_exp(fe[0], fe[3]), b);
    cmd(8'hd5);
    cmd(8'he3);
    chk("idle flags", {4'h0, fe}, {4'h0, fl});
    chk("idle col", c + 8'h01, col_addr);
    cmd(8'had);
    cmd(8'haf);
    chk("ind", {5'h00, 2'h3, fe[3]}, {5'h00, static_ind_mode, display_on});
    cmd(8'hac);
    $display("end of test access");
    cmd(8'hae);
    cmd(8'ha5);
    chk("sleep", 8'h09, {4'h0, sleep_mode, osc_enable, power_enable, drivers_grounded});
    chk("kept", {5'h00, fe[2:0]}, {5'h00, fl[2:0]});
    setcol(c);
    u_host.put(1'b1, 8'h5a);
    setcol(c);
    u_host.get(1'b1, b);
    chk("sleep ram", 8'h5a, b);
    cmd(8'ha4);
    chb("half release", 1'b1, sleep_mode);
    cmd(8'had);
    cmd(8'h03);
    chk("awake", 8'h01, {6'h00, sleep_mode, power_enable});
    cmd(8'ha5);
    chk("standby", 8'h1b, {3'h0, standby_mode, osc_enable, power_enable, drivers_grounded,
      static_drive_enable});
    cmd(8'he2);
    chk("reset sleep", 8'h02, {6'h00, sleep_mode, standby_mode});
    wake();
    $display("end of test power");
    cmd(8'hf5);
    chb("test on", 1'b1, test_mode);
    u_host.refresh();
    chb("test off", 1'b0, test_mode);
    cmd(8'hc8);
    chb("com dir", 1'b1, com_reverse);
    cmd(8'hf3);
    cmd(8'he2);
    chk("soft reset", 8'h00, {test_mode, start_line, display_on});
    chb("com dir clear", 1'b0, com_reverse);
    cmd({4'hb, pg});
    setcol(c);
    u_host.get(1'b1, b);
    chk("ram kept", 8'h5a, b);
    cmd(8'hff);
    @(negedge clk);
    hard_init_pin_n = 1'b0;
    @(negedge clk);
    hard_init_pin_n = 1'b1;
    chb("hard init", 1'b0, test_mode);
    $display("end of test reset");
    stop_test;
  end
endmodule // tb_top
